// File: verilog/ttu_bank.sv
// trace-unstable event flags, thresholds and indirect buffer access
`timescale 1ns/1ps
module ttu_bank
   import ttu_pkg::*;
(
   input wire logic clk, // 10 MHz clock
   input wire logic rst, // synchronous reset, high
   input wire logic [11:0] addr, // register byte offset
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic msg_valid, // trace message received
   input wire logic [2:0] msg_grp, // its group, 0..6
   input wire logic [1:0] msg_mem, // its member, 0..3
   input wire logic msg_differs, // differs from previous
   input wire logic msg_long, // 64-byte message
   input wire logic tu3_mode, // single large tributary mode
   input wire logic [13:0] grp_fmt, // 2-bit format per group
   input wire logic cap_wr, // capture byte write
   input wire logic [2:0] cap_grp, // capture group
   input wire logic [1:0] cap_mem, // capture member
   input wire logic [5:0] cap_addr, // capture byte index
   input wire logic [7:0] cap_data, // capture byte
   output logic [13:0] alarm_o, // unstable alarms, members 3 then 4
   output logic int_o // unstable interrupt, high
);
   logic [6:0] ev3_q, ev3_d; // third member event flags
   logic [6:0] ev4_q, ev4_d; // fourth member event flags
   logic [7:0] thr_q, thr_d; // thresholds
   logic [2:0] ctl_q, ctl_d; // enable, algorithm, persistence
   logic [7:0] sel_q, sel_d; // page, group, member
   logic [6:0] adr_q, adr_d; // direction and byte index
   logic [7:0] dat_q, dat_d; // indirect data
   logic [7:0] rdata_q, rdata_d; // read data register
   ttu_acc_t st_q, st_d; // access sequencer
   logic [13:0] alm_prev_q; // alarms one cycle ago
   logic [13:0] alm; // current alarms
   logic [6:0] ok3, ok4; // flag positions in use
   logic [13:0] chg; // alarm changes
   logic [11:0] acc_idx; // software access location
   logic [7:0] buf_rd; // buffer read byte
   logic buf_we; // software buffer write
   logic [7:0] buf_mem [0:4095]; // capture and expected pages

   ////////////////////////////////////////////////////////////////
   // detectors for members 3 and 4 of every group
   genvar gi;
   generate
      for (gi = 0; gi < NDET; gi++) begin : g_det
         ttu_det_if dif ();
         assign dif.msg_valid = msg_valid && msg_grp == 3'(gi % NGRP)
                                && msg_mem == 2'(2 + gi / NGRP);
         assign dif.msg_differs = msg_differs;
         assign dif.msg_long = msg_long;
         assign dif.alternate_count_algorithm = ctl_q[CTL_ALG];
         assign dif.persistence_select = ctl_q[CTL_PER];
         assign dif.thr16 = thr_q[3:0];
         assign dif.thr64 = thr_q[7:4];
         assign alm[gi] = dif.alarm;
         ttu_det u_det (
            .clk(clk),
            .rst(rst),
            .d(dif)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // which flag positions exist under the current formats
   always_comb begin
      for (int g = 0; g < NGRP; g++) begin
         // VT6 and VT3 groups have no third member
         ok3[g] = !tu3_mode && grp_fmt[2*g +: 2] != FMT_VT6
                  && grp_fmt[2*g +: 2] != FMT_VT3;
         // only VT1.5 groups have a fourth member
         ok4[g] = !tu3_mode && grp_fmt[2*g +: 2] == FMT_VT15;
      end
   end

   assign chg = alm ^ alm_prev_q;

   ////////////////////////////////////////////////////////////////
   // event flags: set on an alarm change at a flag position in use, cleared by a read
   always_comb begin
      ev3_d = ev3_q;
      ev4_d = ev4_q;
      // clear first so that a change in the read cycle survives
      if (rd && addr == OFS_EV3) ev3_d = 7'h00;
      if (rd && addr == OFS_EV4) ev4_d = 7'h00;
      // bit g is group g; interrupt enable is not consulted
      ev3_d = (ev3_d | chg[6:0]) & ok3;
      ev4_d = (ev4_d | chg[13:7]) & ok4;
   end

   ////////////////////////////////////////////////////////////////
   // software registers and access trigger
   always_comb begin
      thr_d = thr_q;
      ctl_d = ctl_q;
      sel_d = sel_q;
      adr_d = adr_q;
      st_d = st_q;
      buf_we = 1'b0;
      acc_idx = buf_idx(sel_q[4:2], sel_q[1:0], sel_q[SEL_PAGE], adr_q[5:0]);
      if (wr) begin
         unique case (addr)
            OFS_THR: thr_d = wdata;
            OFS_CTL: ctl_d = wdata[2:0];
            OFS_SEL: sel_d = {wdata[7], 2'b00, wdata[4:0]};
            OFS_ADR: begin
               // a trigger during an access is ignored
               if (st_q == ST_IDLE) begin
                  adr_d = wdata[6:0];
                  st_d = ST_RUN;
               end
            end
            default: ;
         endcase
      end
      unique case (st_q)
         ST_IDLE: ;
         ST_RUN: begin
            // capture writes own the buffer; software waits until cap_wr drops
            if (!cap_wr) begin
               buf_we = !adr_q[ADR_DIR];
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // indirect data: software loads it, a finished read replaces it
   always_comb begin
      dat_d = dat_q;
      if (wr && addr == OFS_DAT) dat_d = wdata;
      if (st_q == ST_RUN && !cap_wr && adr_q[ADR_DIR]) dat_d = buf_rd;
   end

   ////////////////////////////////////////////////////////////////
   // read data, presented the cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      if (rd) begin
         unique case (addr)
            OFS_EV3: rdata_d = {1'b0, ev3_q & ok3};
            OFS_EV4: rdata_d = {1'b0, ev4_q & ok4};
            OFS_THR: rdata_d = thr_q;
            OFS_SEL: rdata_d = sel_q;
            OFS_ADR: rdata_d = {st_q == ST_RUN, adr_q};
            OFS_DAT: rdata_d = dat_q;
            OFS_CTL: rdata_d = {5'h00, ctl_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // buffer array: capture port wins, no reset on storage
   assign buf_rd = buf_mem[acc_idx];

   always_ff @(posedge clk) begin
      if (cap_wr) begin
         buf_mem[buf_idx(cap_grp, cap_mem, 1'b1, cap_addr)] <= cap_data;
      end else if (buf_we) begin
         buf_mem[acc_idx] <= dat_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ev3_q <= 7'h00;
         ev4_q <= 7'h00;
         thr_q <= THR_RST;
         ctl_q <= 3'h0;
         sel_q <= 8'h00;
         adr_q <= 7'h00;
         dat_q <= 8'h00;
         rdata_q <= 8'h00;
         st_q <= ST_IDLE;
         alm_prev_q <= 14'h0000;
      end else begin
         ev3_q <= ev3_d;
         ev4_q <= ev4_d;
         thr_q <= thr_d;
         ctl_q <= ctl_d;
         sel_q <= sel_d;
         adr_q <= adr_d;
         dat_q <= dat_d;
         rdata_q <= rdata_d;
         st_q <= st_d;
         alm_prev_q <= alm;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign rdata = rdata_q;
   assign alarm_o = alarm_prev_unused_guard(alm_prev_q);
   assign int_o = ctl_q[CTL_IEN] && (|ev3_q || |ev4_q);

   // alarms leave through flops so outputs stay glitch free
   function automatic logic [13:0] alarm_prev_unused_guard(input logic [13:0] a);
      alarm_prev_unused_guard = a;
   endfunction : alarm_prev_unused_guard
endmodule : ttu_bank

// File: verilog/ttu_pkg.sv
// constants and types for the trace-unstable register bank
package ttu_pkg;
   localparam int NGRP = 7; // tributary groups
   localparam int NDET = 14; // detectors: members 3 and 4 of each group
   // register byte offsets
   localparam logic [11:0] OFS_EV3 = 12'h426;
   localparam logic [11:0] OFS_EV4 = 12'h427;
   localparam logic [11:0] OFS_THR = 12'h428;
   localparam logic [11:0] OFS_SEL = 12'h429;
   localparam logic [11:0] OFS_ADR = 12'h42A;
   localparam logic [11:0] OFS_DAT = 12'h42B;
   localparam logic [11:0] OFS_CTL = 12'h42C;
   // field positions and reset values
   localparam int CTL_IEN = 0; // unstable_interrupt_enable
   localparam int CTL_ALG = 1; // alternate_count_algorithm
   localparam int CTL_PER = 2; // persistence_select
   localparam int SEL_PAGE = 7; // page_select
   localparam int ADR_BUSY = 7;
   localparam int ADR_DIR = 6; // access_direction
   localparam logic [7:0] THR_RST = 8'h77;
   localparam logic [2:0] PER_SHORT = 3'h3;
   localparam logic [2:0] PER_LONG = 3'h5;
   // group formats
   localparam logic [1:0] FMT_VT15 = 2'h0;
   localparam logic [1:0] FMT_VT2 = 2'h1;
   localparam logic [1:0] FMT_VT3 = 2'h2;
   localparam logic [1:0] FMT_VT6 = 2'h3;
   // indirect access sequencer
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} ttu_acc_t;

   // buffer index: tributary, page, byte
   function automatic logic [11:0] buf_idx(input logic [2:0] g, input logic [1:0] m,
                                           input logic p, input logic [5:0] a);
      buf_idx = {g, m, p, a};
   endfunction : buf_idx
endpackage : ttu_pkg

// File: verilog/ttu_det_if.sv
// per-tributary link between register bank and unstable detector
`timescale 1ns/1ps
interface ttu_det_if;
   logic msg_valid; // message received for this tributary
   logic msg_differs; // differs from the previous message
   logic msg_long; // 64-byte message
   logic alternate_count_algorithm; // alternate counting algorithm
   logic persistence_select; // five repeats to accept
   logic [3:0] thr16; // 16-byte threshold
   logic [3:0] thr64; // 64-byte threshold
   logic alarm; // unstable alarm state
   modport bank (output msg_valid, msg_differs, msg_long, alternate_count_algorithm, persistence_select, thr16, thr64, input alarm);
   modport det (input msg_valid, msg_differs, msg_long, alternate_count_algorithm, persistence_select, thr16, thr64, output alarm);
endinterface : ttu_det_if

// File: verilog/ttu_det.sv
// trace-unstable alarm detector for one tributary
`timescale 1ns/1ps
module ttu_det
   import ttu_pkg::*;
(
   input wire logic clk, // 10 MHz clock
   input wire logic rst, // synchronous reset, high
   ttu_det_if.det d // controls and alarm
);
   logic [4:0] cnt_q, cnt_d; // unstable counter, saturates
   logic [2:0] per_q, per_d; // consecutive identical receipts
   logic run_q, run_d; // alternate algorithm counting
   logic alm_q, alm_d; // alarm state
   logic [4:0] thr; // applicable threshold
   logic [2:0] need; // repeats needed to accept

   ////////////////////////////////////////////////////////////////
   // next state per received message
   always_comb begin
      cnt_d = cnt_q;
      per_d = per_q;
      run_d = run_q;
      alm_d = alm_q;
      thr = {1'b0, d.msg_long ? d.thr64 : d.thr16};
      need = d.persistence_select ? PER_LONG : PER_SHORT;
      if (d.msg_valid) begin
         if (d.msg_differs) begin
            per_d = 3'h1; // new candidate seen once
            // dropping the alternate bit also stops a count already running
            run_d = d.alternate_count_algorithm;
            if (cnt_q != 5'h1F) cnt_d = cnt_q + 5'h01;
         end else begin
            if (per_q != 3'h7) per_d = per_q + 3'h1;
            if (per_d >= need) begin
               // accepted message ends instability
               cnt_d = 5'h00;
               run_d = 1'b0;
               alm_d = 1'b0;
            end else if (run_q && d.alternate_count_algorithm && cnt_q != 5'h1F) begin
               cnt_d = cnt_q + 5'h01;
            end
         end
         if (cnt_d > thr) alm_d = 1'b1;
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 5'h00;
         per_q <= 3'h0;
         run_q <= 1'b0;
         alm_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         per_q <= per_d;
         run_q <= run_d;
         alm_q <= alm_d;
      end
   end

   assign d.alarm = alm_q;
endmodule : ttu_det

// File: dv/ttu_bank_chk.sv
// port assertions for the trace-unstable register bank
`timescale 1ns/1ps
module ttu_bank_chk
   import ttu_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic [11:0] addr, // offset
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic msg_valid, // message pulse
   input wire logic tu3_mode, // large mode
   input wire logic [13:0] grp_fmt, // formats
   input wire logic [13:0] alarm_o, // alarms
   input wire logic int_o // interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic ev; // read of either event register
   assign ev = rd && (addr == OFS_EV3 || addr == OFS_EV4);
   ////////////////////////////////////////
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
   a_unused_bit: assert property (ev |=> !rdata[7]) else $error("bit 7 set");
   a_large_zero: assert property (ev && tu3_mode |=> rdata == 8'h00) else $error("flags in large mode");
   a_third_fmt: assert property (rd && addr == OFS_EV3 && grp_fmt[1] |=> !rdata[0])
      else $error("third flag in wide format");
   a_fourth_fmt: assert property (rd && addr == OFS_EV4 && grp_fmt[1:0] != FMT_VT15 |=> !rdata[0])
      else $error("fourth flag in wide format");
   a_read_clear: assert property (ev ##1 (rd && $stable(addr) && $stable(alarm_o)) |=> rdata == 8'h00)
      else $error("flags survive read");
   a_alarm_src: assert property ($changed(alarm_o) |-> $past(msg_valid, 2)) else $error("alarm moved alone");
   a_int_fall: assert property ($fell(int_o) |-> $past(ev) || $past(wr) ||
      $past(tu3_mode) != $past(tu3_mode, 2) || $past(grp_fmt) != $past(grp_fmt, 2)) else $error("int fell");
   a_int_rise: assert property ($rose(int_o) |-> $changed(alarm_o) || $past(wr)) else $error("int rose");
   a_thr_rw: assert property (wr && addr == OFS_THR ##2 (rd && addr == OFS_THR) |=> rdata == $past(wdata, 3))
      else $error("threshold lost");
endmodule : ttu_bank_chk
bind ttu_bank ttu_bank_chk ttu_bank_chk_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .msg_valid(msg_valid), .tu3_mode(tu3_mode), .grp_fmt(grp_fmt), .alarm_o(alarm_o), .int_o(int_o));

// File: dv/ttu_cpu.sv
// microprocessor model on the register port
`timescale 1ns/1ps
module ttu_cpu
   import ttu_pkg::*;
(
   input wire logic clk, // clock
   input wire logic [7:0] rdata, // read data
   output logic [11:0] addr, // offset
   output logic [7:0] wdata, // write data
   output logic wr, // write strobe
   output logic rd // read strobe
);
   initial begin
      addr = 12'h000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // released lines show the inverse so stale values never pass
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : wr_reg
   // two back-to-back reads of one place
   task automatic rd_reg(input logic [11:0] a, output logic [7:0] q1, output logic [7:0] q2);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk) #1 q1 = rdata;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1 q2 = rdata;
   endtask : rd_reg
   // indirect access; n reaches 20 if busy never drops
   task automatic ind(input logic [7:0] sel, input logic [7:0] adr, input logic [7:0] d, output logic [7:0] q,
                      output int n);
      logic [7:0] s, t;
      wr_reg(OFS_SEL, sel);
      if (!adr[ADR_DIR]) wr_reg(OFS_DAT, d);
      wr_reg(OFS_ADR, adr);
      s = 8'h80;
      for (n = 0; n < 20 && s[ADR_BUSY]; n++) rd_reg(OFS_ADR, s, t);
      rd_reg(OFS_DAT, q, t);
   endtask : ind
endmodule : ttu_cpu

// File: dv/tb_ttu_bank.sv
// self-checking bench for the trace-unstable register bank
`timescale 1ns/1ps
module tb_ttu_bank;
   import ttu_pkg::*;
   logic clk = 1'b0, rst = 1'b1, msg_valid = 1'b0, msg_differs = 1'b0, msg_long = 1'b0, tu3_mode = 1'b0;
   logic cap_wr = 1'b0, wr, rd, int_o;
   logic [2:0] msg_grp = 3'h0, cap_grp = 3'h0;
   logic [1:0] msg_mem = 2'h0, cap_mem = 2'h0;
   logic [5:0] cap_addr = 6'h00;
   logic [7:0] cap_data = 8'h00, wdata, rdata, thr, ctl, q, q2, sel;
   logic [13:0] grp_fmt = 14'h0000, alarm_o, e;
   logic [11:0] addr;
   logic [31:0] r;
   int seed = 85706, n_mismatch = 0, samples_checked = 0, polls;
   int cnt[14], rep[14], alm[14], run[14], flg[14]; // model per tributary
   always #50 clk = ~clk;
   ttu_cpu ttu_cpu_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   ttu_bank ttu_bank_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .msg_valid(msg_valid), .msg_grp(msg_grp), .msg_mem(msg_mem), .msg_differs(msg_differs), .msg_long(msg_long),
      .tu3_mode(tu3_mode), .grp_fmt(grp_fmt), .cap_wr(cap_wr), .cap_grp(cap_grp), .cap_mem(cap_mem),
      .cap_addr(cap_addr), .cap_data(cap_data), .alarm_o(alarm_o), .int_o(int_o));
   ////////////////////////////////////////
   function automatic bit used(int i);
      return !tu3_mode && (i < 7 ? !grp_fmt[2*(i%7)+1] : grp_fmt[2*(i%7)+:2] == FMT_VT15);
   endfunction : used
   task automatic chk(string n, logic [13:0] x, logic [13:0] s);
      samples_checked++;
      if (s !== x) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   // one message, then alarm and interrupt against the model
   task automatic msg(int i, bit df, bit lg);
      int o;
      o = alm[i];
      @(posedge clk);
      msg_grp <= 3'(i % 7);
      msg_mem <= 2'(i / 7 + 2);
      msg_differs <= df;
      msg_long <= lg;
      msg_valid <= 1'b1;
      @(posedge clk);
      msg_valid <= 1'b0;
      if (df) begin
         rep[i] = 1;
         cnt[i]++;
         run[i] = ctl[CTL_ALG];
      end else begin
         rep[i]++;
         cnt[i] += run[i] & int'(ctl[CTL_ALG]);
      end
      if (rep[i] >= (ctl[CTL_PER] ? 5 : 3)) begin
         cnt[i] = 0;
         alm[i] = 0;
         run[i] = 0;
      end
      if (cnt[i] > (lg ? thr[7:4] : thr[3:0])) alm[i] = 1;
      if (alm[i] != o && used(i)) flg[i] = 1;
      repeat (3) @(posedge clk);
      #1;
      for (int k = 0; k < 14; k++) e[k] = alm[k] != 0;
      chk("alarm", e, alarm_o);
      chk("int", ctl[CTL_IEN] && flg.sum() > 0, int_o);
   endtask : msg
   task automatic rdev(int m);
      e = '0;
      for (int g = 0; g < 7; g++) begin
         e[g] = flg[m*7+g] != 0 && used(m*7+g);
         flg[m*7+g] = 0;
      end
      ttu_cpu_i.rd_reg(m ? OFS_EV4 : OFS_EV3, q, q2);
      chk("events", e, q);
      chk("events again", 0, q2);
   endtask : rdev
   // indirect access; a busy that never drops ends the run as a failure
   task automatic ind_acc(logic [7:0] s, logic [7:0] a, logic [7:0] d);
      ttu_cpu_i.ind(s, a, d, q, polls);
      if (polls >= 20) begin
         n_mismatch++;
         $display("wrong value busy expected 0 seen 1");
         stop_test();
      end
   endtask : ind_acc
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      ttu_cpu_i.rd_reg(OFS_THR, q, q2);
      chk("threshold reset", THR_RST, q);
      ttu_cpu_i.rd_reg(12'h430, q, q2);
      chk("unmapped", 0, q);
      // every mix of algorithm, persistence and enable
      for (int ph = 0; ph < 8; ph++) begin
         rdev(0);
         rdev(1);
         thr = 8'($random(seed)) & 8'h33;
         ctl = 8'(ph);
         // read straight back, two cycles after the write
         ttu_cpu_i.wr_reg(OFS_THR, thr);
         ttu_cpu_i.rd_reg(OFS_THR, q, q2);
         chk("threshold", thr, q);
         ttu_cpu_i.wr_reg(OFS_CTL, ctl);
         tu3_mode <= ph == 7;
         grp_fmt <= ph > 3 ? 14'($random(seed)) : 14'h0000;
         for (int k = 0; k < 120; k++) begin
            r = $random(seed);
            msg(int'(r[2:0]) % 7 + 7 * int'(r[4]), r[9:8] == 2'b00, r[12]);
            if (k % 10 == 9) rdev(k / 10 % 2);
         end
      end
      // page isolation through indirect writes and reads
      for (int k = 0; k < 8; k++) begin
         r = $random(seed);
         sel = {r[7], 2'b00, 3'(r[10:8] % 7), r[1:0]};
         ind_acc(sel, {2'b00, r[21:16]}, r[31:24]);
         ind_acc(sel ^ 8'h80, {2'b00, r[21:16]}, ~r[31:24]);
         ind_acc(sel, {2'b01, r[21:16]}, 8'h00);
         chk("buffer byte", r[31:24], q);
      end
      // capture writes hold the access busy, then read back
      @(posedge clk);
      cap_grp <= 3'h5;
      cap_mem <= 2'h3;
      cap_addr <= 6'h2A;
      cap_data <= 8'hC3;
      cap_wr <= 1'b1;
      fork
         begin
            repeat (8) @(posedge clk);
            cap_wr <= 1'b0;
         end
      join_none
      ind_acc(8'h97, 8'h6A, 8'h00);
      chk("capture byte", 8'hC3, q);
      chk("busy polls", 1, polls > 1 && polls < 20);
      stop_test();
   end
endmodule : tb_ttu_bank
